// ---- src/bms_pkg.sv ----
// Shared constants, carriers and states of the block-move/swap/trap unit
package bms_pkg;

  // ----------------------------------------------------------------------
  // Instruction fields
  // ----------------------------------------------------------------------
  localparam int BIT_LOAD  = 20;   // load_store_select
  localparam int BIT_WBACK = 21;   // base_update_select
  localparam int BIT_UBANK = 22;   // user_bank_or_status_select
  localparam int BIT_BYTE  = 22;   // byte_word_select
  localparam int BIT_UP    = 23;   // up_down_select
  localparam int BIT_PRE   = 24;   // pre_post_select
  localparam int BIT_SETS  = 20;   // status-setting bit of a move

  localparam logic [3:0] REG_LINK = 4'hE;
  localparam logic [3:0] REG_PC   = 4'hF;

  // ----------------------------------------------------------------------
  // Register banking and status layout
  // ----------------------------------------------------------------------
  localparam int         PHYS_REGS     = 18;
  localparam logic [4:0] PHYS_BANK_OFS = 5'h03;  // r13/r14 -> 16/17
  localparam logic [4:0] PHYS_LINK_SVC = 5'h11;
  localparam logic [4:0] MODE_USER     = 5'h10;
  localparam logic [4:0] MODE_SVC      = 5'h13;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0013;

  // ----------------------------------------------------------------------
  // Addresses and offsets
  // ----------------------------------------------------------------------
  localparam logic [31:0] PC_RESET       = 32'h0000_0000;
  localparam logic [31:0] TRAP_VECTOR    = 32'h0000_0008;
  localparam logic [31:0] FAULT_VECTOR   = 32'h0000_0010;
  localparam logic [31:0] WORD_STEP      = 32'h0000_0004;
  localparam logic [31:0] PC_STORE_ADJ   = 32'h0000_000C;
  localparam logic [31:0] FAULT_LINK_ADJ = 32'h0000_0008;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        req;
    logic        we;
    logic        byte_sel;
    logic [31:0] addr;
    logic [31:0] wdata;
  } bms_mem_req_t;

  typedef struct packed {
    logic        ack;
    logic        fault;
    logic [31:0] rdata;
  } bms_mem_rsp_t;

  typedef struct packed {
    logic        en;
    logic [4:0]  idx;
    logic [31:0] data;
  } bms_rf_wr_t;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'b0000,
    ST_RD_BASE  = 4'b0001,
    ST_RD_SRC   = 4'b0010,
    ST_SWP_RD   = 4'b0011,
    ST_SWP_WR   = 4'b0100,
    ST_SWP_DST  = 4'b0101,
    ST_MV_EXEC  = 4'b0110,
    ST_BLK_SCAN = 4'b0111,
    ST_BLK_RD   = 4'b1000,
    ST_BLK_MEM  = 4'b1001,
    ST_BLK_END  = 4'b1010,
    ST_FAULT    = 4'b1011
  } bms_state_t;

endpackage : bms_pkg

// ---- src/bms_regfile.sv ----
// Banked register file with one write port and a registered read port
`timescale 1ns/1ps
module bms_regfile #(
  parameter int NREG = 18
) (
  input  wire logic               clock,    // Core clock
  input  wire logic               rst_n,    // Synchronous reset, active low
  input  wire bms_pkg::bms_rf_wr_t wr,      // Write port
  input  wire logic [4:0]         raddr,    // Read index
  output logic [31:0]             rdata     // Read data, one cycle late
);
  import bms_pkg::*;

  logic [31:0] mem_r [NREG];

  always_ff @(posedge clock) begin
    if (wr.en) begin
      mem_r[wr.idx] <= wr.data;
    end
  end

  // Read-before-write: a same-cycle write shows on the next access
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdata <= '0;
    end else begin
      rdata <= mem_r[raddr];
    end
  end

endmodule : bms_regfile

// ---- src/bms_exec.sv ----
// Execution unit for multiple transfer, swap, trap and status return
//
// Function
// (RQ1) Skip instruction whose condition fails, no effects
// (RQ2) Load, pre, up bits decode independently
// (RQ3) Write final address back only when requested
// (RQ4) Status copy with PC load, else user bank
// (RQ5) Swap reads then writes; no interrupt between
// (RQ6) Swap: address base, store source, load dest
// (RQ7) Lock held across swap read and write
// (RQ8) Swap moves byte or word per select bit
// (RQ9) Swap lanes follow ordinary load and store
// (RQ10) Fault on either swap access takes trap
// (RQ11) Swap abort independent of late fault setting
// (RQ12) Trap enters supervisor, saves status, fixed vector
// (RQ13) Trap link holds address after trap word
// (RQ14) Status-restoring move returns and restores status
// (RQ15) Trap comment field ignored entirely
// (RQ16) Lock released after swap write, even faulted
`timescale 1ns/1ps
module bms_exec #(
  parameter logic [31:0] DATA_FAULT_VECTOR = bms_pkg::FAULT_VECTOR
) (
  input  wire logic                 clock,           // 20 MHz core clock
  input  wire logic                 rst_n,           // Sync reset, low
  input  wire logic [31:0]          instr_in,        // Instruction word
  input  wire logic                 instr_valid_in,  // Instruction offered
  output logic                      instr_ready_out, // Instruction taken
  output bms_pkg::bms_mem_req_t     mem_req_out,     // Memory request
  input  wire bms_pkg::bms_mem_rsp_t mem_rsp_in,     // Memory answer
  output logic                      indivisible_access_out, // Swap lock
  input  wire logic                 big_endian_in,   // Byte order
  input  wire logic                 irq_req_in,      // Interrupt request
  output logic                      irq_accept_out,  // Interrupt taken
  output logic                      done_out,        // Instruction retired
  output logic                      fault_trap_out,  // Data fault trap
  output logic [31:0]               pc_out,          // Program counter
  output logic [31:0]               status_out       // Status word
);
  import bms_pkg::*;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic cond_pass(input logic [3:0] c,
                                     input logic [3:0] f);
    logic n, z, cy, v, r;
    n  = f[3];
    z  = f[2];
    cy = f[1];
    v  = f[0];
    unique case (c[3:1])
      3'h0: r = z;
      3'h1: r = cy;
      3'h2: r = n;
      3'h3: r = v;
      3'h4: r = cy & ~z;
      3'h5: r = (n == v);
      3'h6: r = ~z & (n == v);
      3'h7: r = 1'b1;
    endcase
    // Odd codes invert; the last code never passes
    return (c[3:1] == 3'h7) ? ~c[0] : (r ^ c[0]);
  endfunction : cond_pass

  function automatic logic [4:0] phys(input logic [3:0] idx,
                                      input logic       svc,
                                      input logic       user_bank);
    logic [4:0] p;
    p = {1'b0, idx};
    if (svc && !user_bank && (idx == 4'hD || idx == REG_LINK)) begin
      p = p + PHYS_BANK_OFS;
    end
    return p;
  endfunction : phys

  function automatic logic [4:0] popcount(input logic [15:0] l);
    logic [4:0] n;
    n = '0;
    for (int i = 0; i < 16; i++) begin
      n = n + {4'h0, l[i]};
    end
    return n;
  endfunction : popcount

  function automatic logic [3:0] lowest(input logic [15:0] l);
    logic [3:0] k;
    k = '0;
    for (int i = 15; i >= 0; i--) begin
      if (l[i]) begin
        k = 4'(i);
      end
    end
    return k;
  endfunction : lowest

  // Byte lane by address and byte order, zero filled
  function automatic logic [31:0] load_lanes(input logic [31:0] d,
                                             input logic [1:0]  a,
                                             input logic        be,
                                             input logic        byt);
    logic [1:0] lane;
    lane = be ? ~a : a;
    return byt ? {24'h0, 8'(d >> {lane, 3'b000})} : d;
  endfunction : load_lanes

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  bms_state_t  state_r, state_nxt;
  logic [31:0] ir_r, ir_nxt, addr_r, addr_nxt, base_r, base_nxt;
  logic [31:0] wdata_r, wdata_nxt, rdat_r, rdat_nxt;
  logic [31:0] pcld_r, pcld_nxt, pc_r, pc_nxt;
  logic [31:0] current_status_word_r, current_status_word_nxt, spsr_r, spsr_nxt;
  logic [15:0] list_r, list_nxt;
  logic        fault_r, fault_nxt, pcld_v_r, pcld_v_nxt;
  logic        done_r, done_nxt, trap_r, trap_nxt;
  bms_rf_wr_t  rf_wr;
  logic [4:0]  rf_raddr;
  logic [31:0] rf_rdata;
  bms_mem_req_t mreq;

  logic        in_svc, is_blk, is_swp, is_trap, is_status_restoring_move, usr, ld;
  logic [4:0]  cnt;
  logic [31:0] span;
  logic [3:0]  cur;

  // Comment field of the trap is never looked at: only bits 27:24
  assign is_trap = (instr_in[27:24] == 4'hF);                    // RQ15
  assign is_blk  = (instr_in[27:25] == 3'b100);
  assign is_swp  = (instr_in[27:23] == 5'b00010) &&
                   (instr_in[21:20] == 2'b00) &&
                   (instr_in[11:4] == 8'h09);
  assign is_status_restoring_move = (instr_in[27:21] == 7'b0001101) &&
                   instr_in[BIT_SETS] && (instr_in[15:12] == REG_PC) &&
                   (instr_in[11:4] == 8'h00) &&
                   (instr_in[3:0] == REG_LINK);
  assign in_svc  = (current_status_word_r[4:0] == MODE_SVC);
  assign ld      = ir_r[BIT_LOAD];
  // Status copy wins over user bank when a load carries the PC
  assign usr     = ir_r[BIT_UBANK] && !(ld && ir_r[REG_PC]);        // RQ4
  assign cnt     = popcount(ir_r[15:0]);
  assign span    = {25'h0, cnt, 2'b00};
  assign cur     = lowest(list_r);

  bms_regfile #(
    .NREG (PHYS_REGS)
  ) u_rf (
    .clock (clock),
    .rst_n (rst_n),
    .wr    (rf_wr),
    .raddr (rf_raddr),
    .rdata (rf_rdata)
  );

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    state_nxt  = state_r;
    ir_nxt     = ir_r;
    addr_nxt   = addr_r;
    base_nxt   = base_r;
    wdata_nxt  = wdata_r;
    rdat_nxt   = rdat_r;
    pcld_nxt   = pcld_r;
    pcld_v_nxt = pcld_v_r;
    pc_nxt     = pc_r;
    current_status_word_nxt   = current_status_word_r;
    spsr_nxt   = spsr_r;
    list_nxt   = list_r;
    fault_nxt  = fault_r;
    done_nxt   = 1'b0;
    trap_nxt   = 1'b0;
    rf_wr      = '0;
    rf_raddr   = '0;
    mreq       = '0;
    unique case (state_r)
      ST_IDLE: begin
        if (instr_valid_in) begin
          ir_nxt = instr_in;
          if (!cond_pass(instr_in[31:28], current_status_word_r[31:28])) begin
            pc_nxt   = pc_r + WORD_STEP;                              // RQ1
            done_nxt = 1'b1;
          end else if (is_trap) begin
            rf_wr    = '{en: 1'b1, idx: PHYS_LINK_SVC,
                         data: pc_r + WORD_STEP};                    // RQ13
            spsr_nxt = current_status_word_r;                                       // RQ12
            current_status_word_nxt = {current_status_word_r[31:5], MODE_SVC};                     // RQ12
            pc_nxt   = TRAP_VECTOR;                                  // RQ12
            done_nxt = 1'b1;
          end else if (is_status_restoring_move) begin
            rf_raddr  = phys(REG_LINK, in_svc, 1'b0);                // RQ14
            state_nxt = ST_MV_EXEC;
          end else if (is_swp || is_blk) begin
            rf_raddr  = phys(instr_in[19:16], in_svc,
                             is_blk && instr_in[BIT_UBANK] &&
                             !(instr_in[BIT_LOAD] && instr_in[REG_PC]));
            state_nxt = ST_RD_BASE;
          end else begin
            pc_nxt   = pc_r + WORD_STEP;
            done_nxt = 1'b1;
          end
        end
      end
      ST_MV_EXEC: begin
        pc_nxt    = rf_rdata;                                        // RQ14
        current_status_word_nxt  = spsr_r;                                          // RQ14
        done_nxt  = 1'b1;
        state_nxt = ST_IDLE;
      end
      ST_RD_BASE: begin
        fault_nxt  = 1'b0;
        pcld_v_nxt = 1'b0;
        if (ir_r[27:25] != 3'b100) begin
          addr_nxt  = rf_rdata;                                      // RQ6
          rf_raddr  = phys(ir_r[3:0], in_svc, 1'b0);                 // RQ6
          state_nxt = ST_RD_SRC;
        end else begin
          // Lowest register always at lowest address
          unique case ({ir_r[BIT_UP], ir_r[BIT_PRE]})                // RQ2
            2'b11: addr_nxt = rf_rdata + WORD_STEP;
            2'b10: addr_nxt = rf_rdata;
            2'b01: addr_nxt = rf_rdata - span;
            2'b00: addr_nxt = rf_rdata - span + WORD_STEP;
          endcase
          base_nxt  = ir_r[BIT_UP] ? rf_rdata + span : rf_rdata - span;
          list_nxt  = ir_r[15:0];
          state_nxt = ST_BLK_SCAN;
        end
      end
      ST_RD_SRC: begin
        // Byte store replicates over all lanes, like a single store
        wdata_nxt = ir_r[BIT_BYTE] ? {4{rf_rdata[7:0]}} : rf_rdata; // RQ9
        state_nxt = ST_SWP_RD;
      end
      ST_SWP_RD: begin
        mreq = '{req: 1'b1, we: 1'b0, byte_sel: ir_r[BIT_BYTE],
                 addr: addr_r, wdata: wdata_r};                      // RQ8
        if (mem_rsp_in.ack) begin
          rdat_nxt  = load_lanes(mem_rsp_in.rdata, addr_r[1:0],
                                 big_endian_in, ir_r[BIT_BYTE]);     // RQ9
          fault_nxt = fault_r | mem_rsp_in.fault;                    // RQ10
          state_nxt = ST_SWP_WR;                                     // RQ5
        end
      end
      ST_SWP_WR: begin
        mreq = '{req: 1'b1, we: 1'b1, byte_sel: ir_r[BIT_BYTE],
                 addr: addr_r, wdata: wdata_r};                      // RQ6
        if (mem_rsp_in.ack) begin
          fault_nxt = fault_r | mem_rsp_in.fault;                    // RQ10
          state_nxt = ST_SWP_DST;                                    // RQ16
        end
      end
      ST_SWP_DST: begin
        // No base is touched, so late or early fault timing agree
        if (fault_r) begin
          state_nxt = ST_FAULT;                                // RQ10 RQ11
        end else begin
          rf_wr     = '{en: 1'b1, idx: phys(ir_r[15:12], in_svc, 1'b0),
                        data: rdat_r};                               // RQ6
          pc_nxt    = pc_r + WORD_STEP;
          done_nxt  = 1'b1;
          state_nxt = ST_IDLE;
        end
      end
      ST_BLK_SCAN: begin
        if (list_r == '0) begin
          state_nxt = ST_BLK_END;
        end else begin
          rf_raddr  = phys(cur, in_svc, usr);                        // RQ4
          state_nxt = ld ? ST_BLK_MEM : ST_BLK_RD;                   // RQ2
        end
      end
      ST_BLK_RD: begin
        wdata_nxt = (cur == REG_PC) ? pc_r + PC_STORE_ADJ : rf_rdata;
        state_nxt = ST_BLK_MEM;
      end
      ST_BLK_MEM: begin
        mreq = '{req: 1'b1, we: !ld, byte_sel: 1'b0,
                 addr: addr_r, wdata: wdata_r};
        if (mem_rsp_in.ack) begin
          // Register overwriting stops at the first fault
          if (ld && !fault_r && !mem_rsp_in.fault) begin
            if (cur == REG_PC) begin
              pcld_nxt   = mem_rsp_in.rdata;
              pcld_v_nxt = 1'b1;
            end else begin
              rf_wr = '{en: 1'b1, idx: phys(cur, in_svc, usr),
                        data: mem_rsp_in.rdata};                     // RQ4
            end
          end
          fault_nxt = fault_r | mem_rsp_in.fault;
          addr_nxt  = addr_r + WORD_STEP;
          list_nxt  = list_r & ~(16'h0001 << cur);
          state_nxt = ST_BLK_SCAN;
        end
      end
      ST_BLK_END: begin
        if (ir_r[BIT_WBACK] &&
            !(ld && ir_r[ir_r[19:16]] && !fault_r)) begin
          rf_wr = '{en: 1'b1, idx: phys(ir_r[19:16], in_svc, usr),
                    data: base_r};                                   // RQ3
        end
        if (fault_r) begin
          state_nxt = ST_FAULT;
        end else begin
          if (pcld_v_r) begin
            pc_nxt = pcld_r;
            if (ir_r[BIT_UBANK]) begin
              current_status_word_nxt = spsr_r;                                     // RQ4
            end
          end else begin
            pc_nxt = pc_r + WORD_STEP;
          end
          done_nxt  = 1'b1;
          state_nxt = ST_IDLE;
        end
      end
      ST_FAULT: begin
        rf_wr     = '{en: 1'b1, idx: PHYS_LINK_SVC,
                      data: pc_r + FAULT_LINK_ADJ};
        spsr_nxt  = current_status_word_r;
        current_status_word_nxt  = {current_status_word_r[31:5], MODE_SVC};
        pc_nxt    = DATA_FAULT_VECTOR;
        trap_nxt  = 1'b1;                                            // RQ10
        done_nxt  = 1'b1;
        state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_r  <= ST_IDLE;
      ir_r     <= '0;
      addr_r   <= '0;
      base_r   <= '0;
      wdata_r  <= '0;
      rdat_r   <= '0;
      pcld_r   <= '0;
      pcld_v_r <= 1'b0;
      pc_r     <= PC_RESET;
      current_status_word_r   <= STATUS_RESET;
      spsr_r   <= '0;
      list_r   <= '0;
      fault_r  <= 1'b0;
      done_r   <= 1'b0;
      trap_r   <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      ir_r     <= ir_nxt;
      addr_r   <= addr_nxt;
      base_r   <= base_nxt;
      wdata_r  <= wdata_nxt;
      rdat_r   <= rdat_nxt;
      pcld_r   <= pcld_nxt;
      pcld_v_r <= pcld_v_nxt;
      pc_r     <= pc_nxt;
      current_status_word_r   <= current_status_word_nxt;
      spsr_r   <= spsr_nxt;
      list_r   <= list_nxt;
      fault_r  <= fault_nxt;
      done_r   <= done_nxt;
      trap_r   <= trap_nxt;
    end
  end

  assign instr_ready_out = (state_r == ST_IDLE);
  assign mem_req_out     = mreq;
  assign indivisible_access_out = (state_r == ST_SWP_RD) ||
                                  (state_r == ST_SWP_WR);      // RQ7 RQ16
  // Interrupts only between instructions, never inside the lock
  assign irq_accept_out  = irq_req_in && (state_r == ST_IDLE);       // RQ5
  assign done_out        = done_r;
  assign fault_trap_out  = trap_r;
  assign pc_out          = pc_r;
  assign status_out      = current_status_word_r;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  logic take;
  assign take = instr_valid_in && instr_ready_out;

  cond_skip_a: assert property (take &&                              // RQ1
      !cond_pass(instr_in[31:28], status_out[31:28])
      |=> done_out && pc_out == $past(pc_out) + WORD_STEP &&
          status_out == $past(status_out) && !fault_trap_out)
    else $error("failed condition changed state");
  trap_entry_a: assert property (take && is_trap &&                 // RQ12
      cond_pass(instr_in[31:28], status_out[31:28])
      |=> pc_out == TRAP_VECTOR && status_out[4:0] == MODE_SVC &&
          spsr_r == $past(status_out))
    else $error("trap entry wrong");
  trap_link_a: assert property (take && is_trap &&                  // RQ13
      cond_pass(instr_in[31:28], status_out[31:28])
      |-> rf_wr.en && rf_wr.idx == PHYS_LINK_SVC &&
          rf_wr.data == pc_out + WORD_STEP)
    else $error("trap link wrong");
  lock_span_a: assert property (indivisible_access_out &&            // RQ7
      !(mem_req_out.we && mem_rsp_in.ack) |=> indivisible_access_out)
    else $error("lock dropped before swap write done");
  lock_release_a: assert property ((state_r == ST_SWP_WR) &&        // RQ16
      mem_rsp_in.ack |=> !indivisible_access_out ##1
      !indivisible_access_out)
    else $error("lock not released");
  no_irq_lock_a: assert property (indivisible_access_out             // RQ5
      |-> !irq_accept_out)
    else $error("interrupt inside lock");
  swap_order_a: assert property ((state_r == ST_SWP_RD) &&           // RQ5
      mem_rsp_in.ack |=> mem_req_out.req && mem_req_out.we &&
      mem_req_out.addr == $past(mem_req_out.addr))
    else $error("swap write not after read");
  swap_fault_a: assert property ((state_r == ST_SWP_WR) &&          // RQ10
      mem_rsp_in.ack && (fault_r || mem_rsp_in.fault)
      |-> ##3 fault_trap_out && pc_out == DATA_FAULT_VECTOR)
    else $error("swap fault trap missing");
  swap_byte_a: assert property (mem_req_out.req &&                   // RQ8
      indivisible_access_out |-> mem_req_out.byte_sel == ir_r[BIT_BYTE])
    else $error("swap size wrong");
  base_keep_a: assert property ((state_r == ST_BLK_END) &&           // RQ3
      !ir_r[BIT_WBACK] |-> !rf_wr.en)
    else $error("base written without request");
  status_restoring_move_restore_a: assert property ((state_r == ST_MV_EXEC)          // RQ14
      |=> status_out == $past(spsr_r) && pc_out == $past(rf_rdata))
    else $error("status return wrong");

  trap_c:  cover property (take && is_trap);
  swap_c:  cover property ((state_r == ST_SWP_DST) && !fault_r);
  sfail_c: cover property ((state_r == ST_SWP_DST) && fault_r);
  ldmpc_c: cover property ((state_r == ST_BLK_END) && pcld_v_r &&
                           ir_r[BIT_UBANK]);

endmodule : bms_exec

// ---- verification/bms_mem_model.sv ----
// Memory and memory-manager model facing the exchange unit
`timescale 1ns/1ps
module bms_mem_model (
  input  wire logic                  clock, // Core clock
  input  wire bms_pkg::bms_mem_req_t req,   // Core request
  output bms_pkg::bms_mem_rsp_t      rsp,   // Answer to core
  input  wire logic                  lock,  // Swap lock
  input  wire logic                  be,    // Big endian lanes
  input  wire logic                  slow,  // Two wait states
  input  wire logic [1:0]            flt    // Fault on write, read
);
  import bms_pkg::*;
  logic [31:0] mem [16];
  logic [71:0] log_q [64];
  int          n_acc = 0;
  logic [1:0]  wait_r = 2'h0;
  logic [1:0]  ln;
  logic [31:0] word;
  logic        ack_w;
  assign word = mem[req.addr[5:2]];
  assign ln = be ? ~req.addr[1:0] : req.addr[1:0];
  // Answers every request within two wait states, so a locked pair completes
  assign ack_w = req.req && (!slow || wait_r == 2'h2);
  // Bus not answered shows the inverse, not stale data
  assign rsp = '{ack: ack_w, fault: ack_w && flt[req.we],
                 rdata: ack_w ? word : ~word};
  initial for (int i = 0; i < 16; i++) mem[i] = 32'hC0DE_0000 + i * 32'h0101;
  always @(posedge clock) begin
    wait_r <= (req.req && !rsp.ack) ? wait_r + 2'h1 : 2'h0;
    if (rsp.ack) begin
      log_q[n_acc] <= {req.we, lock, req.byte_sel, 5'h0, req.addr, req.wdata};
      n_acc <= n_acc + 1;
      // Faulted writes are blocked by the manager
      if (req.we && !rsp.fault && req.byte_sel)
        mem[req.addr[5:2]][8*ln +: 8] <= req.wdata[7:0];
      else if (req.we && !rsp.fault)
        mem[req.addr[5:2]] <= req.wdata;
    end
  end
endmodule : bms_mem_model

// ---- verification/tb.sv ----
// Self-checking bench for the block move, swap and trap unit
`timescale 1ns/1ps
module tb;
  import bms_pkg::*;
  logic         clock = 1'b0, rst_n = 1'b0, instr_valid_in = 1'b0;
  logic [31:0]  instr_in = 32'h0, pc_out, status_out;
  logic         instr_ready_out, indivisible_access_out, irq_accept_out;
  logic         done_out, fault_trap_out, last_trap, irq_req_in = 1'b0;
  logic         big_endian_in = 1'b0, slow = 1'b0;
  logic [1:0]   flt = 2'h0;
  bms_mem_req_t mem_req;
  bms_mem_rsp_t mem_rsp;
  int           n_fail = 0, checks_done = 0, n0;
  always #25 clock = ~clock;
  bms_exec bms_exec_inst (.clock(clock), .rst_n(rst_n), .instr_in(instr_in),
    .instr_valid_in(instr_valid_in), .instr_ready_out(instr_ready_out),
    .mem_req_out(mem_req), .mem_rsp_in(mem_rsp),
    .indivisible_access_out(indivisible_access_out),
    .big_endian_in(big_endian_in), .irq_req_in(irq_req_in),
    .irq_accept_out(irq_accept_out), .done_out(done_out),
    .fault_trap_out(fault_trap_out), .pc_out(pc_out), .status_out(status_out));
  bms_mem_model bms_mem_model_inst (.clock(clock), .req(mem_req),
    .rsp(mem_rsp), .lock(indivisible_access_out), .be(big_endian_in),
    .slow(slow), .flt(flt));
  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic report_and_stop;
    if (n_fail == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic check(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic step(inout int k);
    @(posedge clock);
    #1 k++;
    if (k > 200) begin
      n_fail++;
      report_and_stop();
    end
  endtask : step
  // Irq is raised only after the take, so idle never sees it
  task automatic run(input logic [31:0] ins, input logic irq);
    int k;
    k = 0;
    n0 = bms_mem_model_inst.n_acc;
    instr_in = ins;
    instr_valid_in = 1'b1;
    while (instr_ready_out !== 1'b1) step(k);
    @(posedge clock);
    #1 instr_valid_in = 1'b0;
    while (done_out !== 1'b1) begin
      irq_req_in = irq && (indivisible_access_out || k < 3);
      step(k);
    end
    irq_req_in = 1'b0;
    last_trap = fault_trap_out;
    step(k);
  endtask : run
  // f: compare data, write, lock, byte select
  task automatic acc(input int k, input logic [3:0] f, input logic [31:0] a, d);
    logic [71:0] e;
    e = bms_mem_model_inst.log_q[n0 + k];
    check("acc flags", {29'h0, e[71:69]}, {29'h0, f[2:0]});
    check("acc addr", e[63:32], a);
    if (f[3]) check("acc data", e[31:0], d);
  endtask : acc
  always @(posedge clock)
    if (indivisible_access_out === 1'b1 && irq_accept_out !== 1'b0) begin
      n_fail++;
      $display("BAD irq_accept exp 0 seen %b", irq_accept_out);
    end
  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    logic [31:0] a;
    repeat (9) @(posedge clock);
    #1 irq_req_in = 1'b1;
    @(posedge clock);
    #1 rst_n = 1'b1;
    check("irq idle", {31'h0, irq_accept_out}, 32'h1);
    irq_req_in = 1'b0;
    check("pc", pc_out, PC_RESET);
    check("status", status_out, STATUS_RESET);
    run(32'h0F00_0000, 1'b0);
    check("skip pc", pc_out, 32'h4);
    run(32'hEFAB_CDEF, 1'b0);
    check("trap pc", pc_out, TRAP_VECTOR);
    check("trap mode", status_out, STATUS_RESET);
    run(32'hE8BE_0003, 1'b0);
    acc(0, 4'h0, 32'h8, 32'h0);
    acc(1, 4'h0, 32'hC, 32'h0);
    run(32'hE10E_2090, 1'b1);
    acc(0, 4'h2, 32'h10, 32'h0);
    acc(1, 4'hE, 32'h10, 32'hC0DE_0202);
    check("swap trap", {31'h0, last_trap}, 32'h0);
    check("unlock", {31'h0, indivisible_access_out}, 32'h0);
    run(32'hE88E_0004, 1'b0);
    acc(0, 4'hC, 32'h10, 32'hC0DE_0404);
    run(32'hE14E_3091, 1'b1);
    acc(1, 4'hF, 32'h10, 32'h0303_0303);
    run(32'hE88E_0008, 1'b0);
    acc(0, 4'hC, 32'h10, 32'h4);
    big_endian_in = 1'b1;
    run(32'hE14E_3091, 1'b1);
    run(32'hE88E_0008, 1'b0);
    acc(0, 4'hC, 32'h10, 32'h0);
    big_endian_in = 1'b0;
    slow = 1'b1;
    for (int f = 1; f < 4; f++) begin
      flt = f[1:0];
      run(32'hE10E_2090, 1'b1);
      check("flt trap", {31'h0, last_trap}, 32'h1);
      check("flt pc", pc_out, FAULT_VECTOR);
      check("flt pair", 32'(bms_mem_model_inst.n_acc - n0), 32'h2);
      check("flt lock", {31'h0, indivisible_access_out}, 32'h0);
    end
    flt = 2'h0;
    slow = 1'b0;
    for (int m = 0; m < 8; m++) begin
      run({7'h74, m[1], m[0], 2'h0, m[2], 20'hE0003}, 1'b0);
      a = m[0] ? (m[1] ? 32'h1C : 32'h18) : (m[1] ? 32'h10 : 32'h14);
      acc(0, {1'b0, ~m[2], 2'h0}, a, 32'h0);
      acc(1, {1'b0, ~m[2], 2'h0}, a + 32'h4, 32'h0);
    end
    run(32'hE1B0_F00E, 1'b0);
    check("return pc", pc_out, 32'h18);
    check("return status", status_out, STATUS_RESET);
    report_and_stop();
  end
endmodule : tb
